// File: rtl/flash_spi_pkg.sv
// Constants and types shared by the serial flash interface front end
// Overview of operation
// - Sample serial input on clock rising edge
// - Shift serial output on clock falling edge
// - Serial output shows ready/busy during auto-increment
// - Select only on chip select falling edge
// - Modes idle-low and idle-high share edges
// - Enter pause when pause low, clock low
// - Leave pause when pause high, clock low
// - Paused: output floats, clock and data ignored
// - Deselect while paused resets interface logic
// - Stay paused while pause input low
// - Refuse status write: protect low, lock set
// - Protect levels and lock guard writes (here only lock with protect low refuses status writes; levels are only output)
// - Lock bit clears to zero at reset
// - Eight-bit cycles, most significant bit first
// - Early deselect aborts partial bus cycle
package flash_spi_pkg;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int PIN_COUNT = 5;
  localparam int PIN_SCK = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_HOLD = 3;
  localparam int PIN_WP = 4;
  // Idle levels: protect, pause and select high, data and clock low
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 5'h1A;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam int LOCK_BIT = 7;
  localparam int LEVEL_MSB = 5;
  localparam int LEVEL_LSB = 2;
  localparam logic LOCK_RESET = 1'h0;
  localparam logic [3:0] LEVEL_RESET = 4'h7;
  typedef enum logic [2:0] {
    LINK_IDLE = 3'b001,
    LINK_ACTIVE = 3'b010,
    LINK_PAUSED = 3'b100
  } link_state_t;
endpackage

// File: rtl/serial_flash_spi_front_end.sv
// Serial flash interface front end with receive byte FIFO
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];
  localparam logic [AW:0] ONE_COUNT = {{AW{1'b0}}, 1'b1};
  localparam logic [AW-1:0] ONE_PTR = {{(AW-1){1'b0}}, 1'b1};
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_write;
  logic do_read;

  assign in_ready_out = (count != FULL_COUNT);
  assign do_write = in_valid_in && in_ready_out;
  assign do_read = (count != '0) && (!out_valid_out || out_ready_in);

  always_ff @(posedge clock_in) begin
    if (clk_en_in && do_write) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // Pointers wrap naturally; depth is a power of two
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (clk_en_in) begin
      if (do_write) begin
        wr_ptr <= wr_ptr + ONE_PTR;
      end
      if (do_read) begin
        rd_ptr <= rd_ptr + ONE_PTR;
      end
      if (do_write && !do_read) begin
        count <= count + ONE_COUNT;
      end else if (!do_write && do_read) begin
        count <= count - ONE_COUNT;
      end
    end
  end

  // Registered output stage
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      out_data_out <= '0;
      out_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      if (do_read) begin
        out_data_out <= mem[rd_ptr];
        out_valid_out <= 1'b1;
      end else if (out_ready_in) begin
        out_valid_out <= 1'b0;
      end
    end
  end
endmodule

module serial_flash_spi_front_end
  import flash_spi_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic spi_sck_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_si_in,
  input wire logic spi_hold_n_in,
  input wire logic spi_wp_n_in,
  output logic spi_so_out,
  output logic spi_so_oe_n_out,
  input wire logic [BYTE_W-1:0] tx_data_in,
  output logic tx_taken_out,
  output logic [BYTE_W-1:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  output logic rx_overrun_out,
  output logic selected_out,
  output logic paused_out,
  output logic abort_out,
  input wire logic auto_increment_program_in,
  input wire logic flash_busy_in,
  output logic ready_busy_out,
  input wire logic write_status_cmd_in,
  input wire logic [BYTE_W-1:0] status_wdata_in,
  output logic status_done_out,
  output logic status_refused_out,
  output logic protect_lock_bit_out,
  output logic [3:0] block_protect_level_out
);
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] sync1;
  logic [PIN_COUNT-1:0] sync2;
  logic [PIN_COUNT-1:0] sync3;
  logic [PIN_COUNT-1:0] filt;
  logic [PIN_COUNT-1:0] filt_d;
  link_state_t state;
  link_state_t next_state;
  logic [2:0] bit_cnt;
  logic [BYTE_W-1:0] rx_shift;
  logic [BYTE_W-1:0] tx_shift;
  logic so_bit;
  logic loaded;
  logic sck_f;
  logic cs_f;
  logic si_f;
  logic hold_f;
  logic wp_f;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic active;
  logic byte_push;
  logic fifo_ready;
  logic status_allowed;

  assign pin_raw = {spi_wp_n_in, spi_hold_n_in, spi_si_in, spi_cs_n_in, spi_sck_in};

  // Three-stage synchroniser; level changes once stages two and three agree
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
    always_ff @(posedge clock_in) begin
      if (rst_in) begin
        sync1[i] <= PIN_IDLE[i];
        sync2[i] <= PIN_IDLE[i];
        sync3[i] <= PIN_IDLE[i];
        filt[i] <= PIN_IDLE[i];
        filt_d[i] <= PIN_IDLE[i];
      end else if (clk_en_in) begin
        sync1[i] <= pin_raw[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i]) begin
          filt[i] <= sync3[i];
        end
        filt_d[i] <= filt[i];
      end
    end
  end

  assign sck_f = filt[PIN_SCK];
  assign cs_f = filt[PIN_CS];
  assign si_f = filt[PIN_SI];
  assign hold_f = filt[PIN_HOLD];
  assign wp_f = filt[PIN_WP];
  // same edges in both clock idle modes
  assign sck_rise = sck_f && !filt_d[PIN_SCK];
  assign sck_fall = !sck_f && filt_d[PIN_SCK];
  assign cs_fall = !cs_f && filt_d[PIN_CS];
  assign cs_rise = cs_f && !filt_d[PIN_CS];
  assign active = (state == LINK_ACTIVE);

  always_comb begin
    next_state = state;
    case (state)
      LINK_IDLE: begin
        if (cs_fall) begin
          next_state = LINK_ACTIVE;
        end
      end
      LINK_ACTIVE: begin
        if (cs_f) begin
          next_state = LINK_IDLE;
        end else if (!sck_f && !hold_f) begin
          next_state = LINK_PAUSED;
        end
      end
      LINK_PAUSED: begin
        if (cs_f) begin
          next_state = LINK_IDLE;
        end else if (!sck_f && hold_f) begin
          next_state = LINK_ACTIVE;
        end
      end
      default: begin
        next_state = LINK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= LINK_IDLE;
      selected_out <= 1'b0;
      paused_out <= 1'b0;
      spi_so_oe_n_out <= 1'b1;
    end else if (clk_en_in) begin
      state <= next_state;
      selected_out <= (next_state != LINK_IDLE);
      paused_out <= (next_state == LINK_PAUSED);
      spi_so_oe_n_out <= (next_state != LINK_ACTIVE);
    end
  end

  // Receive shifter
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      bit_cnt <= BIT_FIRST;
      rx_shift <= '0;
    end else if (clk_en_in) begin
      if (cs_f) begin
        bit_cnt <= BIT_FIRST;
        rx_shift <= '0;
      end else if (active && sck_rise) begin
        rx_shift <= {rx_shift[BYTE_W-2:0], si_f};
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  assign byte_push = active && sck_rise && (bit_cnt == BIT_LAST);

  // The link cannot be stalled; a full FIFO drops the byte and flags it
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_overrun_out <= 1'b0;
    end else if (clk_en_in) begin
      if (byte_push && !fifo_ready) begin
        rx_overrun_out <= 1'b1;
      end else if (cs_fall) begin
        rx_overrun_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      abort_out <= 1'b0;
    end else if (clk_en_in) begin
      abort_out <= cs_rise && (state != LINK_IDLE) && ((bit_cnt != BIT_FIRST) || (state == LINK_PAUSED));
    end
  end

  byte_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .in_data_in({rx_shift[BYTE_W-2:0], si_f}),
    .in_valid_in(byte_push),
    .in_ready_out(fifo_ready),
    .out_data_out(rx_data_out),
    .out_valid_out(rx_valid_out),
    .out_ready_in(rx_ready_in)
  );

  // Transmit shifter; in idle-high mode the first byte loads on the first fall
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_shift <= '0;
      so_bit <= 1'b0;
      loaded <= 1'b0;
      tx_taken_out <= 1'b0;
    end else if (clk_en_in) begin
      tx_taken_out <= 1'b0;
      if (cs_f) begin
        loaded <= 1'b0;
      end else if (cs_fall && !sck_f) begin
        tx_shift <= {tx_data_in[BYTE_W-2:0], 1'b0};
        so_bit <= tx_data_in[BYTE_W-1];
        loaded <= 1'b1;
        tx_taken_out <= 1'b1;
      end else if (byte_push) begin
        loaded <= 1'b0;
      end else if (active && sck_fall) begin
        if (!loaded) begin
          tx_shift <= {tx_data_in[BYTE_W-2:0], 1'b0};
          so_bit <= tx_data_in[BYTE_W-1];
          loaded <= 1'b1;
          tx_taken_out <= 1'b1;
        end else begin
          tx_shift <= {tx_shift[BYTE_W-2:0], 1'b0};
          so_bit <= tx_shift[BYTE_W-1];
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      spi_so_out <= 1'b0;
      ready_busy_out <= 1'b1;
    end else if (clk_en_in) begin
      ready_busy_out <= !flash_busy_in;
      spi_so_out <= auto_increment_program_in ? !flash_busy_in : so_bit;
    end
  end

  // protect pin low with lock set refuses
  assign status_allowed = wp_f || !protect_lock_bit_out;

  // protection bits, lock cleared at reset
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      protect_lock_bit_out <= LOCK_RESET;
      block_protect_level_out <= LEVEL_RESET;
      status_done_out <= 1'b0;
      status_refused_out <= 1'b0;
    end else if (clk_en_in) begin
      status_done_out <= write_status_cmd_in && status_allowed;
      status_refused_out <= write_status_cmd_in && !status_allowed;
      if (write_status_cmd_in && status_allowed) begin
        protect_lock_bit_out <= status_wdata_in[LOCK_BIT];
        block_protect_level_out <= status_wdata_in[LEVEL_MSB:LEVEL_LSB];
      end
    end
  end

  sequence s_pause_request;
    clk_en_in && active && !cs_f && !sck_f && !hold_f;
  endsequence
  sequence s_resume_request;
    clk_en_in && (state == LINK_PAUSED) && !cs_f && !sck_f && hold_f;
  endsequence

  a_rx_bit_count: assert property (@(posedge clock_in) disable iff (rst_in)
    clk_en_in && active && !cs_f && sck_rise |=> bit_cnt == $past(bit_cnt) + 3'h1)
    else $error("bit count did not advance on rising edge");
  a_tx_on_fall: assert property (@(posedge clock_in) disable iff (rst_in)
    clk_en_in && active && !cs_f && sck_fall && loaded |=> so_bit == $past(tx_shift[BYTE_W-1]))
    else $error("output bit not shifted on falling edge");
  a_busy_on_output: assert property (@(posedge clock_in) disable iff (rst_in)
    clk_en_in && auto_increment_program_in |=> spi_so_out == !$past(flash_busy_in))
    else $error("ready/busy level wrong on serial output");
  a_select_edge: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(selected_out) |-> $past(cs_fall))
    else $error("selected without chip select falling edge");
  a_pause_enter: assert property (@(posedge clock_in) disable iff (rst_in)
    s_pause_request |=> paused_out && spi_so_oe_n_out)
    else $error("pause not entered with clock low");
  a_pause_exit: assert property (@(posedge clock_in) disable iff (rst_in)
    s_resume_request |=> !paused_out && !spi_so_oe_n_out)
    else $error("pause not left with clock low");
  a_pause_freeze: assert property (@(posedge clock_in) disable iff (rst_in)
    (state == LINK_PAUSED) && !cs_f |=> $stable(bit_cnt) && $stable(rx_shift))
    else $error("shifter moved while paused");
  a_deselect_clear: assert property (@(posedge clock_in) disable iff (rst_in)
    clk_en_in && cs_f |=> bit_cnt == BIT_FIRST && !selected_out && spi_so_oe_n_out)
    else $error("deselect did not reset interface");
  a_status_refuse: assert property (@(posedge clock_in) disable iff (rst_in)
    clk_en_in && write_status_cmd_in && !wp_f && protect_lock_bit_out
    |=> status_refused_out && protect_lock_bit_out && $stable(block_protect_level_out))
    else $error("locked status write was not refused");
  a_abort_early: assert property (@(posedge clock_in) disable iff (rst_in)
    clk_en_in && cs_rise && active && (bit_cnt != BIT_FIRST) |=> abort_out)
    else $error("partial byte not aborted on deselect");
endmodule

// File: verification/spi_master_model.sv
// Bus master model driving the serial flash pins
`timescale 1ns/1ps
module spi_master_model (
  input wire logic so_in,
  input wire logic so_oe_n_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  output logic hold_n_out
);
  logic idle_level = 1'b0;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
    hold_n_out = 1'b1;
  end
  task automatic frame_on(input logic m3);
    idle_level = m3;
    sck_out = m3;
    #64 cs_n_out = 1'b0;
    #64;
  endtask
  task automatic frame_off();
    sck_out = idle_level;
    #64 cs_n_out = 1'b1;
    // Released data line shows no stale bit
    si_out = ~si_out;
    #64;
  endtask
  task automatic xfer(input logic [7:0] tx, input int n, input int p, input bit cut, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      sck_out = 1'b0;
      si_out = tx[7 - i];
      #32;
      if (i == p) begin
        hold_n_out = 1'b0;
        repeat (4) #64 {sck_out, si_out} = ~{sck_out, si_out};
        #64;
        if (cut) begin
          cs_n_out = 1'b1;
          #64 hold_n_out = 1'b1;
          return;
        end
        hold_n_out = 1'b1;
        #64;
      end
      sck_out = 1'b1;
      #32 rx = {rx[6:0], so_oe_n_in ? 1'bx : so_in};
    end
  endtask
endmodule

// File: verification/tb_serial_flash_spi_front_end.sv
// Self-checking bench for the serial flash front end
`timescale 1ns/1ps
module tb_serial_flash_spi_front_end
  import flash_spi_pkg::*;
;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic sck, cs_n, si, hold_n, so, so_oe_n, tx_taken, rx_valid, overrun, selected, paused, abort_p;
  logic wp_n = 1'b1;
  logic rx_ready = 1'b0;
  logic aip = 1'b0;
  logic busy = 1'b0;
  logic bprev = 1'b0;
  logic aprev = 1'b0;
  logic wsc = 1'b0;
  logic rb, done, refused, lock;
  logic [3:0] level;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rx_data;
  logic [7:0] loaded[$];
  logic [7:0] exp_rx[$];
  int failures = 0;
  int comparisons = 0;
  int aborts = 0;
  int paused_cyc = 0;
  bit stall = 1'b0;

  always #4 clock_in = ~clock_in;

  serial_flash_spi_front_end dut (
    .clock_in(clock_in), .rst_in(rst_in), .clk_en_in(1'b1), .spi_sck_in(sck), .spi_cs_n_in(cs_n),
    .spi_si_in(si), .spi_hold_n_in(hold_n), .spi_wp_n_in(wp_n), .spi_so_out(so), .spi_so_oe_n_out(so_oe_n),
    .tx_data_in(tx_data), .tx_taken_out(tx_taken), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
    .rx_ready_in(rx_ready), .rx_overrun_out(overrun), .selected_out(selected), .paused_out(paused),
    .abort_out(abort_p), .auto_increment_program_in(aip), .flash_busy_in(busy), .ready_busy_out(rb),
    .write_status_cmd_in(wsc), .status_wdata_in(wdata), .status_done_out(done),
    .status_refused_out(refused), .protect_lock_bit_out(lock), .block_protect_level_out(level)
  );
  spi_master_model m (
    .so_in(so), .so_oe_n_in(so_oe_n), .sck_out(sck), .cs_n_out(cs_n), .si_out(si), .hold_n_out(hold_n)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clock_in) begin
    if (tx_taken === 1'b1) begin
      loaded.push_back(tx_data);
      tx_data <= 8'($urandom);
    end
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      check(rx_data, exp_rx.size() > 0 ? exp_rx.pop_front() : 8'hXX);
    if (abort_p === 1'b1) aborts++;
    if (paused === 1'b1) begin
      paused_cyc++;
      check(so_oe_n, 1'b1);
    end
    if (aip === 1'b1) check(rb, !bprev);
    if (aip === 1'b1 && aprev === 1'b1) check(so, !bprev);
    aprev = aip;
    bprev = busy;
    busy <= 1'($urandom);
    rx_ready <= stall ? 1'b0 : 1'($urandom);
  end

  task automatic status_test();
    logic [1:0] grp [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic lk = 1'b0;
    logic [3:0] lv = 4'h7;
    logic [7:0] d;
    logic rf;
    for (int g = 0; g < 4; g++) begin
      wp_n <= grp[g][1];
      repeat (8) @(posedge clock_in);
      repeat (2) begin
        d = {grp[g][0], 7'($urandom)};
        rf = !grp[g][1] && lk;
        if (!rf) begin
          lk = d[7];
          lv = d[5:2];
        end
        @(posedge clock_in);
        wsc <= 1'b1;
        wdata <= d;
        @(posedge clock_in);
        wsc <= 1'b0;
        @(negedge clock_in);
        check(refused, rf);
        check(done, !rf);
        check({lock, level}, {lk, lv});
      end
    end
    $display("status test done");
  endtask

  task automatic frame(input logic m3, input int nb, input int nbit, input int p, input bit cut);
    logic [7:0] tx, rx;
    int a0, p0;
    bit drop, last;
    a0 = aborts;
    p0 = paused_cyc;
    drop = 1'b0;
    loaded.delete();
    m.frame_on(m3);
    for (int k = 0; k < nb; k++) begin
      tx = 8'($urandom);
      last = (k == nb - 1);
      m.xfer(tx, last ? nbit : 8, last ? p : 8, last && cut, rx);
      if (!last || (nbit == 8 && !cut)) begin
        check(rx, loaded.size() > k ? loaded[k] : 8'hXX);
        // Output stage holds one byte beyond the FIFO depth
        if (exp_rx.size() < FIFO_DEPTH + 1) exp_rx.push_back(tx);
        else drop = 1'b1;
      end
    end
    m.frame_off();
    check(overrun, drop);
    check(8'(aborts - a0), (nbit < 8 || cut) ? 8'h01 : 8'h00);
    check(paused_cyc > p0, p < 8);
    check({selected, paused}, 2'h0);
    $display("frame test done, mode3 %0d", m3);
  endtask

  task automatic drain();
    stall = 1'b0;
    for (int i = 0; i < 3000 && exp_rx.size() > 0; i++) @(posedge clock_in);
    check(8'(exp_rx.size()), 8'h00);
  endtask

  initial begin
    void'($urandom(32'h272C));
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    #1;
    check({lock, level}, 8'h07);
    check(rx_valid, 1'b0);
    $display("reset test done");
    status_test();
    frame(0, 3, 8, 8, 0);
    frame(1, 3, 8, 8, 0);
    frame(0, 2, 8, 3, 0);
    frame(1, 1, 8, 5, 0);
    frame(0, 2, 5, 8, 0);
    frame(1, 1, 8, 8, 0);
    frame(0, 1, 8, 2, 1);
    frame(0, 2, 8, 8, 0);
    stall = 1'b1;
    frame(1, 18, 8, 8, 0);
    drain();
    frame(0, 1, 8, 8, 0);
    drain();
    aip <= 1'b1;
    repeat (60) @(posedge clock_in);
    aip <= 1'b0;
    $display("busy test done");
    complete_run();
  end

  initial begin
    #200000;
    failures++;
    complete_run();
  end
endmodule
